// ==== hdl/acf_defs.vh ====
`ifndef ACF_DEFS_VH
`define ACF_DEFS_VH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define ACF_ADDR_DATA_FIRST 6'h02
`define ACF_ADDR_DATA_LAST 6'h07
`define ACF_ADDR_STATUS1 6'h08
`define ACF_ADDR_STATUS2 6'h09
`define ACF_ADDR_CFG1 6'h0D
`define ACF_ADDR_CFG2 6'h0E

// ---------------------------------------------------------------
// interface_and_detect_config fields
// ---------------------------------------------------------------
`define ACF_CFG1_HOLD 3
`define ACF_CFG1_REARM 4
`define ACF_CFG1_THREE_WIRE 5
`define ACF_CFG1_I2C_SEL 6
`define ACF_CFG1_SPI_SEL 7
`define ACF_CFG1_WR_MASK 8'hF8

// ---------------------------------------------------------------
// fifo_burst_and_trigger_config fields
// ---------------------------------------------------------------
`define ACF_CFG2_WRAP 0
`define ACF_CFG2_FIFO_BURST 1
`define ACF_CFG2_STREAM 5

// ---------------------------------------------------------------
// status fields, resets, modes
// ---------------------------------------------------------------
`define ACF_ST1_EMPTY 4
`define ACF_ST1_FULL 5
`define ACF_ST2_COMBINED 7
`define ACF_CFG_RST 8'h00
`define ACF_MODE_COMBINED 3'h6
`define ACF_CMD_READ 7

`endif

// ==== hdl/acf_spi_link.v ====
`timescale 1ns/1ps
`default_nettype none

// serial link engine, mode 0, msb first
module acf_spi_link
(
    // clock and reset
    input wire core_clk,
    input wire reset,
    // control from the register bank
    input wire linkEnable,
    input wire threeWire,
    input wire readPhase,
    input wire [7:0] txByte,
    // link pins
    input wire sclkPin,
    input wire csPin_n,
    input wire mosiPin,
    input wire sdioIn,
    output reg sdoOut_ff,
    output reg sdoOen_n_ff,
    // received bytes
    output reg rxValid_ff,
    output reg [7:0] rxByte_ff,
    output reg rxFirst_ff,
    output reg frameActive_ff
);

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    reg sclkMeta_ff; // first stage, read only by the second
    reg sclkSync_ff;
    reg sclkPrev_ff; // edge finder history
    reg csMeta_ff;
    reg csSync_ff;
    reg mosiMeta_ff;
    reg mosiSync_ff;
    reg sdioMeta_ff;
    reg sdioSync_ff;

    // shift state
    reg [2:0] bitCnt_ff;
    reg [6:0] rxSh_ff;
    reg [6:0] txSh_ff;
    reg firstByte_ff;

    wire sclkRise = sclkSync_ff & ~sclkPrev_ff;
    wire sclkFall = ~sclkSync_ff & sclkPrev_ff;
    wire dataBit = threeWire ? sdioSync_ff : mosiSync_ff; // 3-wire shares the out pin

    // two flops per pin before any logic looks at it
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            sclkMeta_ff <= 1'b0;
            sclkSync_ff <= 1'b0;
            sclkPrev_ff <= 1'b0;
            csMeta_ff <= 1'b1;
            csSync_ff <= 1'b1;
            mosiMeta_ff <= 1'b0;
            mosiSync_ff <= 1'b0;
            sdioMeta_ff <= 1'b0;
            sdioSync_ff <= 1'b0;
        end
        else
        begin
            sclkMeta_ff <= sclkPin;
            sclkSync_ff <= sclkMeta_ff;
            sclkPrev_ff <= sclkSync_ff;
            csMeta_ff <= csPin_n;
            csSync_ff <= csMeta_ff;
            mosiMeta_ff <= mosiPin;
            mosiSync_ff <= mosiMeta_ff;
            sdioMeta_ff <= sdioIn;
            sdioSync_ff <= sdioMeta_ff;
        end
    end

    // ---------------------------------------------------------------
    // framing and shifting
    // ---------------------------------------------------------------
    // a frame that is disabled when select falls is ignored to its end
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            frameActive_ff <= 1'b0;
            firstByte_ff <= 1'b0;
            bitCnt_ff <= 3'd0;
            rxSh_ff <= 7'd0;
            txSh_ff <= 7'd0;
            rxValid_ff <= 1'b0;
            rxByte_ff <= 8'h00;
            rxFirst_ff <= 1'b0;
            sdoOut_ff <= 1'b0;
            sdoOen_n_ff <= 1'b1;
        end
        else
        begin
            rxValid_ff <= 1'b0;
            if (csSync_ff)
            begin
                // select released: abandon any partial byte
                frameActive_ff <= 1'b0;
                bitCnt_ff <= 3'd0;
            end
            else if (!frameActive_ff && linkEnable && !sclkSync_ff)
            begin
                frameActive_ff <= 1'b1;
                firstByte_ff <= 1'b1;
                bitCnt_ff <= 3'd0;
            end
            else if (frameActive_ff && sclkRise)
            begin
                rxSh_ff <= {rxSh_ff[5:0], dataBit};
                bitCnt_ff <= bitCnt_ff + 3'd1;
                if (bitCnt_ff == 3'd7)
                begin
                    rxValid_ff <= 1'b1;
                    rxByte_ff <= {rxSh_ff, dataBit};
                    rxFirst_ff <= firstByte_ff;
                    firstByte_ff <= 1'b0;
                end
            end
            else if (frameActive_ff && sclkFall)
            begin
                // new byte is taken on the first falling edge of its slot
                if (bitCnt_ff == 3'd0)
                begin
                    sdoOut_ff <= txByte[7];
                    txSh_ff <= txByte[6:0];
                end
                else
                begin
                    sdoOut_ff <= txSh_ff[6];
                    txSh_ff <= {txSh_ff[5:0], 1'b0};
                end
            end
            // 4-wire drives for the whole frame, 3-wire only while reading
            sdoOen_n_ff <= ~(frameActive_ff && !csSync_ff && (!threeWire || readPhase));
        end
    end

endmodule

`default_nettype wire

// ==== hdl/acf_feature_regs.v ====
`timescale 1ns/1ps
`default_nettype none
`include "acf_defs.vh"

// Behaviour
// RULE1: host sets exactly one interface select bit
// RULE2: no sample data while both selects zero
// RULE3: host writes zeros to config low bits
// RULE4: hold set: fifo stops on combined irq
// RULE5: hold clear: fifo keeps capturing normally
// RULE6: rearm set: irq clear rearms detector
// RULE7: rearm clear: detector halted until mode exit
// RULE8: three-wire bit selects 3/4-wire serial wiring
// RULE9: i2c select disables serial link
// RULE10: spi select disables i2c
// RULE11: both zero: keep power-up interface
// RULE12: wrap clear: burst wraps 0x07 to 0x02
// RULE13: wrap set: burst wraps 0x09 to 0x02
// RULE14: standard burst is one six-byte sample
// RULE15: burst bit clear: one sample per transaction
// RULE16: burst bit set: many samples per transaction
// RULE17: stream and full: drop oldest sample
// RULE18: combined mode runs detect, sampling, fifo
// RULE19: after combined irq no further detects
// RULE20: select changes apply between frames only
module acf_feature_regs
#(
    parameter FIFO_DEPTH = 32,
    parameter PTR_W = 5
)
(
    // clock and reset
    input wire core_clk,
    input wire reset,
    // power-up interface strap, high means i2c
    input wire strapI2c,
    // serial link pins
    input wire sclkPin,
    input wire csPin_n,
    input wire mosiPin,
    input wire serialOutIn,
    output wire serialOutOut,
    output wire serialOutOen_n,
    // sample pipeline
    input wire sampleValid,
    input wire [15:0] sampleX,
    input wire [15:0] sampleY,
    input wire [15:0] sampleZ,
    // operating mode and detector
    input wire [2:0] modeSelect,
    input wire fifoEnable,
    input wire motionEvent,
    // status outputs
    output reg spiActive_ff,
    output reg i2cActive_ff,
    output reg combinedIrq_ff
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    reg [7:0] cfg1_ff; // interface_and_detect_config
    reg [7:0] cfg2_ff; // fifo_burst_and_trigger_config
    reg [47:0] xyz_ff; // {z, y, x}, low byte first
    reg [47:0] fifoMem [0:FIFO_DEPTH-1];
    reg [PTR_W-1:0] wrPtr_ff;
    reg [PTR_W-1:0] rdPtr_ff;
    reg [PTR_W:0] count_ff;
    reg detectHalted_ff;
    reg strapMeta_ff; // first stage, read only by the second
    reg strapSync_ff;
    reg strapTaken_ff;
    reg [1:0] strapAge_ff; // edges since release
    reg strapI2c_ff; // latched power-up interface
    reg isRead_ff;
    reg readPhase_ff;
    reg [5:0] addr_ff;
    reg popDone_ff;
    reg [7:0] txByte_ff;
    reg [7:0] nxt_txByte;
    // link engine outputs
    wire rxValid;
    wire [7:0] rxByte;
    wire rxFirst;
    wire frameActive;
    // ---------------------------------------------------------------
    // derived terms
    // ---------------------------------------------------------------
    wire selI2c = cfg1_ff[`ACF_CFG1_I2C_SEL];
    wire selSpi = cfg1_ff[`ACF_CFG1_SPI_SEL];
    wire selAny = selI2c | selSpi;
    wire combinedMode = (modeSelect == `ACF_MODE_COMBINED); // [RULE18]
    wire fifoEmpty = (count_ff == {(PTR_W+1){1'b0}});
    wire fifoFull = (count_ff == FIFO_DEPTH[PTR_W:0]);
    wire frozen = cfg1_ff[`ACF_CFG1_HOLD] & combinedIrq_ff; // [RULE4] [RULE5]
    wire dataByteDone = rxValid & ~rxFirst & isRead_ff;
    wire wrByteDone = rxValid & ~rxFirst & ~isRead_ff;
    wire irqClear = wrByteDone & (addr_ff == `ACF_ADDR_STATUS2);
    wire irqSet = combinedMode & motionEvent & ~detectHalted_ff; // [RULE19]
    wire [5:0] wrapEnd = cfg2_ff[`ACF_CFG2_WRAP] ? `ACF_ADDR_STATUS2
                                                 : `ACF_ADDR_DATA_LAST; // [RULE12] [RULE13]
    // one pop per transaction unless fifo burst is on
    wire fifoPop = dataByteDone & (addr_ff == `ACF_ADDR_DATA_LAST) & fifoEnable & ~fifoEmpty
                   & (cfg2_ff[`ACF_CFG2_FIFO_BURST] | ~popDone_ff); // [RULE15] [RULE16]
    wire takeSample = sampleValid & selAny; // [RULE2]
    wire fifoPush = takeSample & fifoEnable & ~frozen & (~fifoFull | cfg2_ff[`ACF_CFG2_STREAM]);
    wire [47:0] readSample = (fifoEnable && !fifoEmpty) ? fifoMem[rdPtr_ff] : xyz_ff;
    wire [2:0] byteIdx = addr_ff[2:0] - 3'd2;

    // ---------------------------------------------------------------
    // power-up strap capture
    // ---------------------------------------------------------------
    // strap caught once, after the sync chain holds the pin
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            strapMeta_ff <= 1'b0;
            strapSync_ff <= 1'b0;
            strapTaken_ff <= 1'b0;
            strapI2c_ff <= 1'b0;
            strapAge_ff <= 2'h0;
        end
        else
        begin
            strapMeta_ff <= strapI2c;
            strapSync_ff <= strapMeta_ff;
            strapAge_ff <= {strapAge_ff[0], 1'b1};
            if (!strapTaken_ff && strapAge_ff[1])
            begin
                strapTaken_ff <= 1'b1;
                strapI2c_ff <= strapSync_ff;
            end
        end
    end

    // ---------------------------------------------------------------
    // interface enables
    // ---------------------------------------------------------------
    // updated between frames only, never mid-transfer
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            spiActive_ff <= 1'b0;
            i2cActive_ff <= 1'b0;
        end
        else if (!frameActive && strapTaken_ff) // [RULE20]
        begin
            if (selAny)
            begin
                spiActive_ff <= selSpi & ~selI2c; // [RULE9]
                i2cActive_ff <= selI2c & ~selSpi; // [RULE10]
            end
            else
            begin
                // both selects clear: power-up choice stands
                spiActive_ff <= ~strapI2c_ff; // [RULE11]
                i2cActive_ff <= strapI2c_ff; // [RULE11]
            end
        end
    end

    // ---------------------------------------------------------------
    // serial link engine
    // ---------------------------------------------------------------
    acf_spi_link u_link
    (
        .core_clk(core_clk),
        .reset(reset),
        .linkEnable(spiActive_ff),
        .threeWire(cfg1_ff[`ACF_CFG1_THREE_WIRE]), // [RULE8]
        .readPhase(readPhase_ff),
        .txByte(txByte_ff),
        .sclkPin(sclkPin),
        .csPin_n(csPin_n),
        .mosiPin(mosiPin),
        .sdioIn(serialOutIn),
        .sdoOut_ff(serialOutOut),
        .sdoOen_n_ff(serialOutOen_n),
        .rxValid_ff(rxValid),
        .rxByte_ff(rxByte),
        .rxFirst_ff(rxFirst),
        .frameActive_ff(frameActive)
    );

    // ---------------------------------------------------------------
    // transaction decode and register writes
    // ---------------------------------------------------------------
    // first byte is {rw, x, addr[5:0]}; writes auto-increment, reads wrap
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            cfg1_ff <= `ACF_CFG_RST;
            cfg2_ff <= `ACF_CFG_RST;
            isRead_ff <= 1'b0;
            readPhase_ff <= 1'b0;
            addr_ff <= 6'd0;
            popDone_ff <= 1'b0;
        end
        else if (!frameActive)
        begin
            readPhase_ff <= 1'b0;
            popDone_ff <= 1'b0;
        end
        else if (rxValid && rxFirst)
        begin
            isRead_ff <= rxByte[`ACF_CMD_READ];
            readPhase_ff <= rxByte[`ACF_CMD_READ];
            addr_ff <= rxByte[5:0];
        end
        else if (wrByteDone)
        begin
            // low three bits read back zero
            if (addr_ff == `ACF_ADDR_CFG1)
                cfg1_ff <= rxByte & `ACF_CFG1_WR_MASK; // [RULE3]
            if (addr_ff == `ACF_ADDR_CFG2)
                cfg2_ff <= rxByte;
            addr_ff <= addr_ff + 6'd1;
        end
        else if (dataByteDone)
        begin
            if (fifoPop)
                popDone_ff <= 1'b1;
            // wrap back to the first data byte
            if (addr_ff == wrapEnd) // [RULE12] [RULE13] [RULE14]
                addr_ff <= `ACF_ADDR_DATA_FIRST;
            else
                addr_ff <= addr_ff + 6'd1;
        end
    end

    // ---------------------------------------------------------------
    // read data mux
    // ---------------------------------------------------------------
    always @*
    begin
        nxt_txByte = 8'h00;
        case (addr_ff)
            `ACF_ADDR_STATUS1:
            begin
                nxt_txByte[`ACF_ST1_EMPTY] = fifoEmpty;
                nxt_txByte[`ACF_ST1_FULL] = fifoFull;
            end
            `ACF_ADDR_STATUS2:
                nxt_txByte[`ACF_ST2_COMBINED] = combinedIrq_ff;
            `ACF_ADDR_CFG1:
                nxt_txByte = cfg1_ff;
            `ACF_ADDR_CFG2:
                nxt_txByte = cfg2_ff;
            default:
            begin
                // data bytes: x low, x high, y low, y high, z low, z high
                if (addr_ff >= `ACF_ADDR_DATA_FIRST && addr_ff <= `ACF_ADDR_DATA_LAST)
                    nxt_txByte = readSample[{byteIdx, 3'b000} +: 8]; // [RULE14]
            end
        endcase
    end

    // registered: stable byte at the link's load edge
    always @(posedge core_clk)
    begin
        if (reset)
            txByte_ff <= 8'h00;
        else
            txByte_ff <= nxt_txByte;
    end

    // ---------------------------------------------------------------
    // output data registers
    // ---------------------------------------------------------------
    // no data lands until an interface is chosen
    always @(posedge core_clk)
    begin
        if (reset)
            xyz_ff <= 48'h0000_0000_0000;
        else if (takeSample) // [RULE2]
            xyz_ff <= {sampleZ, sampleY, sampleX};
    end

    // ---------------------------------------------------------------
    // sample fifo
    // ---------------------------------------------------------------
    // no reset; only counted entries are read
    always @(posedge core_clk)
    begin
        if (fifoPush)
            fifoMem[wrPtr_ff] <= {sampleZ, sampleY, sampleX};
    end

    // a push into a full stream fifo drops the oldest
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            wrPtr_ff <= {PTR_W{1'b0}};
            rdPtr_ff <= {PTR_W{1'b0}};
            count_ff <= {(PTR_W+1){1'b0}};
        end
        else
        begin
            if (fifoPush)
                wrPtr_ff <= wrPtr_ff + {{(PTR_W-1){1'b0}}, 1'b1};
            if (fifoPop || (fifoPush && fifoFull)) // [RULE17]
                rdPtr_ff <= rdPtr_ff + {{(PTR_W-1){1'b0}}, 1'b1};
            if (fifoPush && !fifoFull && !fifoPop)
                count_ff <= count_ff + {{PTR_W{1'b0}}, 1'b1};
            else if (fifoPop && !fifoPush)
                count_ff <= count_ff - {{PTR_W{1'b0}}, 1'b1};
        end
    end

    // ---------------------------------------------------------------
    // combined-detect flag and detector arming
    // ---------------------------------------------------------------
    // a detect in the clearing cycle wins over the clear
    always @(posedge core_clk)
    begin
        if (reset)
        begin
            combinedIrq_ff <= 1'b0;
            detectHalted_ff <= 1'b0;
        end
        else
        begin
            combinedIrq_ff <= irqSet | (combinedIrq_ff & ~irqClear);
            if (irqSet)
                detectHalted_ff <= 1'b1; // [RULE19]
            else if (!combinedMode)
                detectHalted_ff <= 1'b0; // [RULE7]
            else if (irqClear && cfg1_ff[`ACF_CFG1_REARM])
                detectHalted_ff <= 1'b0; // [RULE6]
        end
    end

endmodule

`default_nettype wire

// ==== test/acf_feature_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
// watches the top ports
module acf_feature_checker (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // link pins
    input wire logic sclkPin,
    input wire logic csPin_n,
    input wire logic serialOutOut,
    input wire logic serialOutOen_n,
    // detector and status
    input wire logic [2:0] modeSelect,
    input wire logic motionEvent,
    input wire logic spiActive_ff,
    input wire logic i2cActive_ff,
    input wire logic combinedIrq_ff
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (reset);
    // --------
    // sequences
    // --------
    // select idle
    sequence csIdle;
        csPin_n [*6];
    endsequence
    // flag pending, no frame
    sequence irqUntouched;
        (combinedIrq_ff && csPin_n) [*8];
    endsequence
    // combined-mode event a cycle back
    sequence irqCause;
        $past(motionEvent) && $past(modeSelect) == 3'h6;
    endsequence
    // --------
    // properties
    // --------
    chk_oen_idle: assert property (csIdle |-> serialOutOen_n)
        else $error("data out driven while idle");
    chk_irq_cause: assert property ($rose(combinedIrq_ff) |-> irqCause)
        else $error("flag rose without a cause");
    chk_irq_mode: assert property (
        !combinedIrq_ff && modeSelect != 3'h6 |=> !combinedIrq_ff)
        else $error("flag set outside combined mode");
    chk_irq_hold: assert property (irqUntouched |=> combinedIrq_ff)
        else $error("flag lost without a clear");
    chk_sel_excl: assert property (!(spiActive_ff && i2cActive_ff))
        else $error("both interfaces enabled");
    chk_spi_quiet: assert property ((!spiActive_ff) [*8] |-> serialOutOen_n)
        else $error("data out driven with link off");
    chk_out_stable: assert property (sclkPin [*4] |-> $stable(serialOutOut))
        else $error("data out moved while clock high");
    chk_reset_out: assert property (
        $fell(reset) |-> !spiActive_ff && !i2cActive_ff && serialOutOen_n)
        else $error("outputs not at reset values");
    chk_sel_frame: assert property ($changed(spiActive_ff) |-> $past(csPin_n, 2))
        else $error("select changed inside a frame");
endmodule

bind acf_feature_regs acf_feature_checker u_chk (
    .core_clk(core_clk), .reset(reset), .sclkPin(sclkPin), .csPin_n(csPin_n),
    .serialOutOut(serialOutOut), .serialOutOen_n(serialOutOen_n),
    .modeSelect(modeSelect), .motionEvent(motionEvent),
    .spiActive_ff(spiActive_ff), .i2cActive_ff(i2cActive_ff),
    .combinedIrq_ff(combinedIrq_ff)
);
`default_nettype wire

// ==== test/acf_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// host side of the serial register link, mode 0, msb first
module acf_host_model (
    // core clock
    input wire logic core_clk,
    // link pins
    output var logic sclkPin,
    output var logic csPin_n,
    output var logic mosiPin,
    output var logic hostSdio,
    // level on the shared data line
    input wire logic lineIn
);
    // half link period, 48 ns clock
    int halfNs = 24;
    // idle: clock low, select high
    initial
    begin
        sclkPin = 1'b0;
        csPin_n = 1'b1;
        mosiPin = 1'b0;
        hostSdio = 1'b0;
    end
    // select low, setup first
    task automatic frameStart;
        @(posedge core_clk);
        #1;
        csPin_n = 1'b0;
        #30;
    endtask
    // one byte each way; drv low releases the shared line
    task automatic xfer(input logic [7:0] tx, input logic drv, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            mosiPin = tx[i];
            // released line shows no held level
            hostSdio = drv ? tx[i] : ~hostSdio;
            #(halfNs);
            sclkPin = 1'b1;
            rx[i] = lineIn;
            #(halfNs);
            sclkPin = 1'b0;
        end
    endtask
    // end of frame
    task automatic frameEnd;
        #(halfNs);
        csPin_n = 1'b1;
        mosiPin = ~mosiPin;
        #60;
    endtask
endmodule
`default_nettype wire

// ==== test/acf_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // --------
    // wiring
    // --------
    logic core_clk, reset, strapI2c, sampleValid, fifoEnable, motionEvent;
    logic [15:0] sampleX, sampleY, sampleZ;
    logic [2:0] modeSelect;
    logic [7:0] rx;
    logic [7:0] rxBuf [0:11];
    // high while the link runs three-wire
    logic threeW = 1'b0;
    wire sclkPin, csPin_n, mosiPin, hostSdio, lineLevel;
    wire serialOutOut, serialOutOen_n, spiActive_ff, i2cActive_ff, combinedIrq_ff;
    int n_errors = 0;
    int checked = 0;
    // shared data line
    assign lineLevel = serialOutOen_n ? hostSdio : serialOutOut;
    acf_feature_regs DUT (
        .core_clk(core_clk), .reset(reset), .strapI2c(strapI2c),
        .sclkPin(sclkPin), .csPin_n(csPin_n), .mosiPin(mosiPin),
        .serialOutIn(lineLevel), .serialOutOut(serialOutOut),
        .serialOutOen_n(serialOutOen_n), .sampleValid(sampleValid),
        .sampleX(sampleX), .sampleY(sampleY), .sampleZ(sampleZ),
        .modeSelect(modeSelect), .fifoEnable(fifoEnable), .motionEvent(motionEvent),
        .spiActive_ff(spiActive_ff), .i2cActive_ff(i2cActive_ff),
        .combinedIrq_ff(combinedIrq_ff)
    );
    acf_host_model host (
        .core_clk(core_clk), .sclkPin(sclkPin), .csPin_n(csPin_n),
        .mosiPin(mosiPin), .hostSdio(hostSdio), .lineIn(lineLevel)
    );
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // --------
    // shared tasks
    // --------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // land 1 ns after a rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic regWr(input logic [5:0] a, input logic [7:0] d);
        host.frameStart();
        host.xfer({2'b00, a}, 1'b1, rx);
        host.xfer(d, 1'b1, rx);
        host.frameEnd();
    endtask
    // dummy bytes release the line in three-wire
    task automatic burstRd(input logic [5:0] a, input int n);
        host.frameStart();
        host.xfer({2'b10, a}, 1'b1, rx);
        for (int i = 0; i < n; i++)
            host.xfer(8'h00, !threeW, rxBuf[i]);
        host.frameEnd();
    endtask
    // byte b of sample k
    function automatic logic [7:0] expB(input int k, input int b);
        return b[0] ? {k[3:0], b[3:0]} : {4'h9 - b[3:0], 4'hC - k[3:0]};
    endfunction
    task automatic pushSmp(input int k);
        cyc(1);
        sampleX = {expB(k, 1), expB(k, 0)};
        sampleY = {expB(k, 3), expB(k, 2)};
        sampleZ = {expB(k, 5), expB(k, 4)};
        sampleValid = 1'b1;
        cyc(1);
        sampleValid = 1'b0;
        cyc(2);
    endtask
    task automatic chkSmp(input int k, input int off);
        for (int b = 0; b < 6; b++)
            check("sample", rxBuf[off + b], expB(k, b));
    endtask
    task automatic evt;
        cyc(1);
        motionEvent = 1'b1;
        cyc(1);
        motionEvent = 1'b0;
        cyc(2);
    endtask
    // --------
    // scenarios
    // --------
    task automatic scStart;
        check("spiOn", spiActive_ff, 1'b1);
        check("i2cOff", i2cActive_ff, 1'b0);
        burstRd(6'h0D, 2);
        check("cfgReset", rxBuf[0] | rxBuf[1], 8'h00);
        pushSmp(0);
        burstRd(6'h02, 6);
        for (int b = 0; b < 6; b++)
            check("noData", rxBuf[b], 8'h00);
    endtask
    task automatic scWrap;
        regWr(6'h0D, 8'h80);
        burstRd(6'h0D, 1);
        check("cfg1", rxBuf[0], 8'h80);
        check("i2cOff", i2cActive_ff, 1'b0);
        pushSmp(1);
        burstRd(6'h02, 8);
        chkSmp(1, 0);
        check("wrap7", rxBuf[6], expB(1, 0));
        regWr(6'h0E, 8'h01);
        burstRd(6'h02, 10);
        check("status2", rxBuf[7], 8'h00);
        check("wrap9", rxBuf[8], expB(1, 0));
        regWr(6'h0E, 8'h00);
    endtask
    task automatic scDetect;
        cyc(1);
        modeSelect = 3'h6;
        evt();
        check("irqSet", combinedIrq_ff, 1'b1);
        burstRd(6'h09, 1);
        check("status2", rxBuf[0], 8'h80);
        regWr(6'h09, 8'h00);
        evt();
        check("halted", combinedIrq_ff, 1'b0);
        cyc(1);
        modeSelect = 3'h5;
        cyc(2);
        modeSelect = 3'h6;
        evt();
        check("modeExit", combinedIrq_ff, 1'b1);
        regWr(6'h0D, 8'h90);
        regWr(6'h09, 8'h00);
        evt();
        check("reArm", combinedIrq_ff, 1'b1);
    endtask
    // flag stays pending through this scenario
    task automatic scFifo;
        cyc(1);
        fifoEnable = 1'b1;
        regWr(6'h0D, 8'h88);
        pushSmp(0);
        burstRd(6'h08, 1);
        check("held", rxBuf[0][4], 1'b1);
        regWr(6'h0D, 8'h80);
        for (int k = 1; k < 5; k++)
            pushSmp(k);
        burstRd(6'h02, 12);
        chkSmp(1, 0);
        chkSmp(2, 6);
        burstRd(6'h02, 6);
        chkSmp(2, 0);
        regWr(6'h0E, 8'h02);
        burstRd(6'h02, 12);
        chkSmp(3, 0);
        chkSmp(4, 6);
        burstRd(6'h08, 1);
        check("drained", rxBuf[0][4], 1'b1);
    endtask
    task automatic scThree;
        regWr(6'h0D, 8'hA0);
        threeW = 1'b1;
        host.frameStart();
        check("oenCmd", serialOutOen_n, 1'b1);
        host.xfer(8'h8D, 1'b1, rx);
        host.xfer(8'h00, 1'b0, rx);
        check("cfg3w", rx, 8'hA0);
        check("oenRead", serialOutOen_n, 1'b0);
        host.frameEnd();
        host.frameStart();
        host.xfer(8'h0D, 1'b1, rx);
        host.xfer(8'h40, 1'b1, rx);
        #200;
        check("selHeld", spiActive_ff, 1'b1);
        host.frameEnd();
        check("spiOff", spiActive_ff, 1'b0);
        check("i2cOn", i2cActive_ff, 1'b1);
        regWr(6'h0D, 8'h80);
        check("ignored", spiActive_ff, 1'b0);
    endtask
    // --------
    // main sequence
    // --------
    initial
    begin
        reset = 1'b1;
        strapI2c = 1'b0;
        sampleValid = 1'b0;
        sampleX = 16'h0000;
        sampleY = 16'h0000;
        sampleZ = 16'h0000;
        fifoEnable = 1'b0;
        motionEvent = 1'b0;
        modeSelect = 3'h5;
        cyc(20);
        reset = 1'b0;
        cyc(12);
        scStart();
        scWrap();
        scDetect();
        scFifo();
        scThree();
        close_out();
    end
    // hang guard
    initial
    begin
        #300000;
        n_errors++;
        close_out();
    end
endmodule
`default_nettype wire
